// file: hdl/pio_params.svh
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
// apb register byte offsets
`define PIO_STROBE_OFS 8'h00
`define PIO_ADDR_OFS 8'h04
`define PIO_DATA_OFS 8'h08
`define PIO_CMDSEL_OFS 8'h0c
`define PIO_STATUS_OFS 8'h10
`define PIO_READBACK_OFS 8'h14
`define PIO_LOOP_OFS 8'h18
// strobe register bit positions
`define PIO_STB_MAINT_LOAD 0
`define PIO_STB_END_SEQ 1
`define PIO_STB_THIRD 2
`define PIO_STB_SECOND 3
`define PIO_STB_WRITE_FIRST 6
`define PIO_STB_OVERRIDE 7
`define PIO_STB_READ_FIRST 8
`define PIO_STB_DMA_SET 9
`define PIO_STB_DMA_CLR 10
`define PIO_STB_CLAIM 11
`define PIO_STB_LOOP_CAP 12
// address word fields
`define PIO_MAIN_HI 15
`define PIO_MAIN_LO 10
`define PIO_SUB_HI 9
`define PIO_SUB_LO 6
`define PIO_DEV_HI 5
`define PIO_GLOBAL_CLEAR_ADDR 6'h1f
// reset values
`define PIO_ADDR_RST 16'h0000
`define PIO_DATA_RST 16'h0000
`define PIO_CMD_RST 7'h00
// timing
`define PIO_PCLK_NS 8
`define PIO_CHAN_CLK_NS 599
`define PIO_HALF_CYC (`PIO_CHAN_CLK_NS / (2 * `PIO_PCLK_NS))
`define PIO_BUS_PULSE_NS 150
`define PIO_BUS_PULSE_CYC ((`PIO_BUS_PULSE_NS + `PIO_PCLK_NS - 1) / `PIO_PCLK_NS)
`define PIO_RX_RESET_NS 40
`define PIO_RX_RESET_CYC ((`PIO_RX_RESET_NS + `PIO_PCLK_NS - 1) / `PIO_PCLK_NS)
`endif

// file: hdl/pio_pkg.sv
package pio_pkg;
  // command state register one-hot positions
  typedef enum logic [2:0] {
    PIO_DATA_RECEIVE,
    PIO_SENSE_STATUS,
    PIO_DATA_PRESENT,
    PIO_COMMAND_PRESENT,
    PIO_INITIALISE,
    PIO_INTERRUPT_IDENTIFY,
    PIO_MAINTENANCE
  } pio_cmd_t;
  typedef logic [6:0] pio_cmd_onehot_t;
endpackage

// file: hdl/pio_channel.sv
// Overview of operation
// - first strobe sets enable, loads one-hot command
// - second strobe pulses command flag, sets sent
// - third strobe pulses command again, clears leads
// - command pulse blocked until address sent
// - processor claim: release flag, resend stored command
// - dma set/clear requests drive command flags
// - end-of-sequence strobe clears enable flag
// - channel clock, strobe, inhibit, present lines out
// - several commands under pulse raise fault
// - select plus override rising sets inhibit override
// - address split: main, subchannel, device fields
// - address pulse, sent flag, error sampled trailing
// - end strobe repulses address, clears sent
// - responses captured on channel clock trailing edge
// - global clear decode and power-on preset
// - invalid two-of-five check code flags error
// - info gating only before address pulsed
// - write first strobe pulses info flags
// - maintenance flag selects internal state readout
// - bipolar 150 ns pulses only when selected
// - enable fall gives receiver clear pulse
// - latching receivers and loopback register
// - odd parity per information byte
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pio_params.svh"
module pio_channel #(
  parameter int INFO_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic chan_clk_out,
  output logic receiver_reset_enable,
  output logic command_lead_strobe,
  output logic command_set_inhibit,
  output pio_pkg::pio_cmd_onehot_t present_cmd,
  output logic main_channel_selected,
  output logic [7:0] subchannel_select_onehot,
  output logic address_drive_strobe,
  output logic command_drive_strobe,
  output logic [5:0] addr_pos,
  output logic [5:0] addr_neg,
  output logic [6:0] cmd_pos,
  output logic [6:0] cmd_neg,
  output logic [INFO_W-1:0] info_pos,
  output logic [INFO_W-1:0] info_neg,
  output logic info_gate_block,
  output logic multi_command_fault,
  output logic receiver_clear_pulse,
  output logic global_clear,
  output logic power_on_preset,
  input wire logic handshake_in_pos,
  input wire logic handshake_in_neg,
  input wire logic device_idle_response,
  input wire logic fault_response_lead,
  input wire logic interrupt_in,
  input wire logic [4:0] check_leads,
  input wire logic [INFO_W-1:0] info_rx_pulse
);
  import pio_pkg::*;
  localparam int SW = 10 + INFO_W;
  localparam int HC = `PIO_HALF_CYC;
  localparam int PC = `PIO_BUS_PULSE_CYC;
  localparam int RC = `PIO_RX_RESET_CYC;

  function automatic logic two_of_five(input logic [4:0] v);
    two_of_five = (3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4])) == 3'd2;
  endfunction

  function automatic logic [8:0] with_parity(input logic [7:0] b);
    with_parity = {~^b, b};
  endfunction

  // pins from outside: two flops before any use
  logic [SW-1:0] meta_q, sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {info_rx_pulse, check_leads, interrupt_in, fault_response_lead,
                 device_idle_response, handshake_in_neg, handshake_in_pos};
      sync_q <= meta_q;
    end
  end
  wire s_hs_pos = sync_q[0];
  wire s_hs_neg = sync_q[1];
  wire s_idle = sync_q[2];
  wire s_fault = sync_q[3];
  wire s_irq = sync_q[4];
  wire [4:0] s_check = sync_q[9:5];
  wire [INFO_W-1:0] s_info = sync_q[SW-1:10];

  // channel clock divider; rise and fall ticks mark the phases
  logic [7:0] div_q;
  logic chan_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      chan_q <= 1'b0;
    end else if (div_q == 8'(HC - 1)) begin
      div_q <= '0;
      chan_q <= ~chan_q;
    end else begin
      div_q <= div_q + 8'd1;
    end
  end
  wire half_end = (div_q == 8'(HC - 1));
  wire phase = half_end && !chan_q;
  wire trail = half_end && chan_q;
  assign chan_clk_out = chan_q;

  // power-on preset: one pulse after reset release
  logic por_q, por_done_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_q <= 1'b0;
      por_done_q <= 1'b0;
    end else begin
      por_q <= !por_done_q;
      por_done_q <= 1'b1;
    end
  end
  assign power_on_preset = por_q;

  // apb slave
  logic [15:0] addr_q, data_q;
  logic [2:0] cmdsel_q;
  logic loop_sel_q;
  logic [31:0] prdata_q;
  wire wr = psel && penable && pwrite;
  wire setup = psel && !penable;
  wire hit_stb = paddr == `PIO_STROBE_OFS;
  wire hit_addr = paddr == `PIO_ADDR_OFS;
  wire hit_data = paddr == `PIO_DATA_OFS;
  wire hit_sel = paddr == `PIO_CMDSEL_OFS;
  wire hit_stat = paddr == `PIO_STATUS_OFS;
  wire hit_rb = paddr == `PIO_READBACK_OFS;
  wire hit_loop = paddr == `PIO_LOOP_OFS;
  wire mapped = hit_stb | hit_addr | hit_data | hit_sel | hit_stat | hit_rb | hit_loop;
  wire [15:0] stb = (wr && hit_stb) ? pwdata[15:0] : 16'h0000;
  assign pready = penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  wire s_maint_load = stb[`PIO_STB_MAINT_LOAD];
  wire s_end = stb[`PIO_STB_END_SEQ];
  wire s_third = stb[`PIO_STB_THIRD];
  wire s_second = stb[`PIO_STB_SECOND];
  wire s_wfirst = stb[`PIO_STB_WRITE_FIRST];
  wire s_override = stb[`PIO_STB_OVERRIDE];
  wire s_first = stb[`PIO_STB_READ_FIRST] | s_wfirst;
  wire s_dma_set = stb[`PIO_STB_DMA_SET];
  wire s_dma_clr = stb[`PIO_STB_DMA_CLR];
  wire s_claim = stb[`PIO_STB_CLAIM];
  wire s_loop_cap = stb[`PIO_STB_LOOP_CAP];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= `PIO_ADDR_RST;
      data_q <= `PIO_DATA_RST;
      cmdsel_q <= '0;
      loop_sel_q <= 1'b0;
    end else if (wr) begin
      if (hit_addr) addr_q <= pwdata[15:0];
      if (hit_data) data_q <= pwdata[15:0];
      if (hit_sel) cmdsel_q <= pwdata[2:0];
      if (hit_loop) loop_sel_q <= pwdata[0];
    end
  end

  // address fields
  wire [5:0] main_field = addr_q[`PIO_MAIN_HI:`PIO_MAIN_LO];
  wire [3:0] sub_field = addr_q[`PIO_SUB_HI:`PIO_SUB_LO];
  wire [5:0] dev_addr = addr_q[`PIO_DEV_HI:0];
  assign main_channel_selected = main_field != 6'h00;
  assign subchannel_select_onehot = sub_field[3] ? 8'h00 : 8'(1) << sub_field[2:0];
  assign global_clear = s_maint_load && main_field == `PIO_GLOBAL_CLEAR_ADDR;
  wire flush = global_clear || por_q;

  // flags
  logic enable_q, arm_addr_q, addr_pulse_q, addr_sent_q, addr_second_q;
  logic arm_cmd_q, cmd_pulse_q, cmd_sent_q, cmd_zero_q, dma_release_q;
  logic arm_info_q, info_pulse_q, info_sent_q, maint_q, override_q, error_q;
  logic done_q, ovr_prev_q, sent_clr_q;
  pio_cmd_onehot_t cmd_q;
  wire mcf = cmd_pulse_q && !$onehot0(cmd_q);
  assign multi_command_fault = mcf;
  wire chk_bad = addr_sent_q && !two_of_five(s_check);
  wire addr_go = arm_addr_q && phase;
  wire cmd_go = arm_cmd_q && addr_sent_q && phase;
  wire ovr_rise = s_override && !ovr_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      cmd_q <= `PIO_CMD_RST;
      arm_addr_q <= 1'b0;
      addr_pulse_q <= 1'b0;
      addr_sent_q <= 1'b0;
      addr_second_q <= 1'b0;
      arm_cmd_q <= 1'b0;
      cmd_pulse_q <= 1'b0;
      cmd_sent_q <= 1'b0;
      cmd_zero_q <= 1'b0;
      dma_release_q <= 1'b0;
      arm_info_q <= 1'b0;
      info_pulse_q <= 1'b0;
      info_sent_q <= 1'b0;
      maint_q <= 1'b0;
      override_q <= 1'b0;
      error_q <= 1'b0;
      done_q <= 1'b0;
      ovr_prev_q <= 1'b0;
      sent_clr_q <= 1'b0;
    end else if (flush) begin
      enable_q <= 1'b0;
      cmd_q <= `PIO_CMD_RST;
      arm_addr_q <= 1'b0;
      addr_pulse_q <= 1'b0;
      addr_sent_q <= 1'b0;
      addr_second_q <= 1'b0;
      arm_cmd_q <= 1'b0;
      cmd_pulse_q <= 1'b0;
      cmd_sent_q <= 1'b0;
      cmd_zero_q <= 1'b0;
      dma_release_q <= 1'b0;
      arm_info_q <= 1'b0;
      info_pulse_q <= 1'b0;
      info_sent_q <= 1'b0;
      maint_q <= 1'b0;
      override_q <= 1'b0;
      error_q <= 1'b0;
      done_q <= 1'b0;
      ovr_prev_q <= s_override;
      sent_clr_q <= 1'b0;
    end else begin
      ovr_prev_q <= s_override;
      done_q <= 1'b0;
      if (s_first) begin
        enable_q <= 1'b1;
        cmd_q <= 7'(1) << cmdsel_q;
        arm_addr_q <= 1'b1;
      end
      if (s_wfirst) arm_info_q <= 1'b1;
      if (s_end) begin
        enable_q <= 1'b0;
        // end of sequence drops the command sent flag and the command arm; cmd_q and dma_release_q are kept
        cmd_sent_q <= 1'b0;
        arm_cmd_q <= 1'b0;
        arm_addr_q <= 1'b1;
        addr_second_q <= 1'b1;
      end
      if (s_maint_load) begin
        maint_q <= 1'b1;
        cmd_q <= data_q[6:0];
      end else if (s_end || s_override) begin
        maint_q <= 1'b0;
      end
      if (ovr_rise && main_channel_selected) override_q <= 1'b1;
      if (s_second || s_dma_set) begin
        arm_cmd_q <= 1'b1;
        cmd_zero_q <= 1'b0;
        sent_clr_q <= 1'b0;
      end
      if (s_third || s_dma_clr) begin
        arm_cmd_q <= 1'b1;
        cmd_zero_q <= 1'b1;
        // third strobe zeroes the leads but still records sent; only dma clear drops it
        sent_clr_q <= !s_third;
      end
      if (s_claim) begin
        dma_release_q <= 1'b1;
        arm_cmd_q <= 1'b1;
        cmd_zero_q <= 1'b0;
        sent_clr_q <= 1'b0;
      end
      // address pulse: set on one phase, cleared on the next
      if (addr_go) begin
        addr_pulse_q <= 1'b1;
        arm_addr_q <= 1'b0;
        if (!addr_second_q) addr_sent_q <= 1'b1;
        if (addr_second_q) info_pulse_q <= 1'b1;
      end else if (addr_pulse_q && phase) begin
        addr_pulse_q <= 1'b0;
        error_q <= mcf || chk_bad || s_fault;
        if (addr_second_q) begin
          addr_sent_q <= 1'b0;
          addr_second_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
      if (cmd_go) begin
        cmd_pulse_q <= 1'b1;
        arm_cmd_q <= 1'b0;
      end else if (cmd_pulse_q && phase) begin
        cmd_pulse_q <= 1'b0;
        cmd_sent_q <= !sent_clr_q;
        if (!cmd_zero_q) dma_release_q <= 1'b0;
      end
      // info pulse rides on the first address pulse of a write
      if (arm_info_q && phase && !addr_second_q) begin
        info_pulse_q <= 1'b1;
        info_sent_q <= 1'b1;
        arm_info_q <= 1'b0;
      end else if (info_pulse_q && phase && !addr_go) begin
        info_pulse_q <= 1'b0;
      end
      if (done_q) info_sent_q <= 1'b0;
    end
  end

  // handshake lines take effect on the trailing edge only
  logic sync_resp_q, idle_q, fault_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_resp_q <= 1'b0;
      idle_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (trail) begin
      if (s_hs_pos) sync_resp_q <= 1'b1;
      else if (s_hs_neg) sync_resp_q <= 1'b0;
      idle_q <= s_idle;
      fault_q <= s_fault;
    end
  end

  // bus pulse timers; 150 ns windows per lead group
  logic [7:0] at_q, ct_q, it_q;
  logic [5:0] adr_tx_q;
  logic [6:0] cmd_tx_q;
  logic [INFO_W-1:0] inf_tx_q;
  wire [17:0] inf_word = {with_parity(data_q[15:8]), with_parity(data_q[7:0])};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      at_q <= '0;
      ct_q <= '0;
      it_q <= '0;
      adr_tx_q <= '0;
      cmd_tx_q <= '0;
      inf_tx_q <= '0;
    end else begin
      if (addr_go) begin
        at_q <= 8'(PC);
        adr_tx_q <= addr_second_q ? 6'h00 : dev_addr;
      end else if (at_q != 8'h00) begin
        at_q <= at_q - 8'd1;
      end
      if (cmd_go) begin
        ct_q <= 8'(PC);
        cmd_tx_q <= cmd_zero_q ? 7'h00 : cmd_q;
      end else if (ct_q != 8'h00) begin
        ct_q <= ct_q - 8'd1;
      end
      if (arm_info_q && phase && !info_gate_block) begin
        it_q <= 8'(PC);
        inf_tx_q <= INFO_W'(inf_word);
      end else if (addr_go && addr_second_q) begin
        it_q <= 8'(PC);
        inf_tx_q <= '0;
      end else if (it_q != 8'h00) begin
        it_q <= it_q - 8'd1;
      end
    end
  end
  wire sub_ok = main_channel_selected && !sub_field[3];
  assign address_drive_strobe = (at_q != 8'h00) && sub_ok;
  assign command_drive_strobe = (ct_q != 8'h00) && sub_ok;
  assign command_lead_strobe = ct_q != 8'h00;
  wire info_drive = (it_q != 8'h00) && sub_ok;
  assign addr_pos = address_drive_strobe ? adr_tx_q : 6'h00;
  assign addr_neg = address_drive_strobe ? ~adr_tx_q : 6'h00;
  assign cmd_pos = command_drive_strobe ? cmd_tx_q : 7'h00;
  assign cmd_neg = command_drive_strobe ? ~cmd_tx_q : 7'h00;
  assign info_pos = info_drive ? inf_tx_q : '0;
  assign info_neg = info_drive ? ~inf_tx_q : '0;
  assign info_gate_block = addr_sent_q;
  assign command_set_inhibit = !cmd_pulse_q;
  assign present_cmd = cmd_q;
  assign receiver_reset_enable = enable_q;

  // receiver clear on enable fall; interrupt receiver
  logic en_prev_q, irq_q, init_prev_q, ack_prev_q;
  logic [7:0] rc_q;
  logic [INFO_W-1:0] rx_q, loop_q;
  wire init_l = cmd_q[PIO_INITIALISE];
  wire ack_l = cmd_q[PIO_INTERRUPT_IDENTIFY];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_prev_q <= 1'b0;
      rc_q <= '0;
      irq_q <= 1'b0;
      init_prev_q <= 1'b0;
      ack_prev_q <= 1'b0;
      rx_q <= '0;
      loop_q <= '0;
    end else begin
      en_prev_q <= enable_q;
      init_prev_q <= init_l;
      ack_prev_q <= ack_l;
      if (en_prev_q && !enable_q) rc_q <= 8'(RC);
      else if (rc_q != 8'h00) rc_q <= rc_q - 8'd1;
      if (s_irq) irq_q <= 1'b1;
      else if ((init_prev_q && !init_l) || (ack_prev_q && !ack_l)) irq_q <= 1'b0;
      if (rc_q != 8'h00) rx_q <= '0;
      else rx_q <= rx_q | s_info;
      if (s_loop_cap) loop_q <= inf_tx_q;
    end
  end
  assign receiver_clear_pulse = rc_q != 8'h00;
  wire [INFO_W-1:0] rx_view = loop_sel_q ? loop_q : rx_q;

  // status and readback words
  wire [31:0] status_w = {14'h0000, irq_q, fault_q, idle_q, sync_resp_q, error_q,
    chk_bad, mcf, override_q, maint_q, info_sent_q, info_pulse_q, dma_release_q,
    cmd_sent_q, cmd_pulse_q, addr_sent_q, addr_pulse_q, enable_q, 1'b0};
  wire [31:0] state_w = {9'h000, cmd_q, status_w[17:2]};
  wire [31:0] rb_w = maint_q ? state_w : 32'(rx_view);
  wire [31:0] rd_mux = hit_addr ? {16'h0000, addr_q} :
                       hit_data ? {16'h0000, data_q} :
                       hit_sel ? {29'h0, cmdsel_q} :
                       hit_stat ? status_w :
                       hit_rb ? rb_w :
                       hit_loop ? {31'h0, loop_sel_q} : 32'h00000000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= '0;
    else if (setup && !pwrite) prdata_q <= rd_mux;
  end
endmodule
`default_nettype wire

// file: verif/pio_channel_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "pio_params.svh"
module pio_channel_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic receiver_reset_enable,
  input wire logic command_lead_strobe,
  input wire logic command_set_inhibit,
  input wire pio_pkg::pio_cmd_onehot_t present_cmd,
  input wire logic [7:0] subchannel_select_onehot,
  input wire logic address_drive_strobe,
  input wire logic [5:0] addr_pos,
  input wire logic [5:0] addr_neg,
  input wire logic info_gate_block,
  input wire logic multi_command_fault,
  input wire logic receiver_clear_pulse,
  input wire logic global_clear
);
  import pio_pkg::*;
  logic [15:0] a_q;
  logic v_q;
  logic [4:0] n_q;
  wire logic acc = psel & penable & pwrite;
  wire logic wr_a = acc & (paddr == `PIO_ADDR_OFS);
  wire logic wr_s = acc & (paddr == `PIO_STROBE_OFS);
  // shadow dropped after a global clear until the next address write; the clear leaves the address register alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= '0;
      v_q <= 1'b1;
      n_q <= '0;
    end else begin
      if (wr_a) a_q <= pwdata[15:0];
      v_q <= wr_a | (v_q & ~global_clear);
      n_q <= command_lead_strobe ? n_q + 5'd1 : 5'd0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_onehot;
    wr_s && (pwdata[8] || pwdata[6]) |=> $onehot(present_cmd);
  endproperty
  a_onehot: assert property (p_onehot) else $error("command not one-hot");
  property p_inh;
    !command_set_inhibit |-> info_gate_block;
  endproperty
  a_inh: assert property (p_inh) else $error("command before address");
  property p_flt;
    multi_command_fault |-> !command_set_inhibit && !$onehot0(present_cmd);
  endproperty
  a_flt: assert property (p_flt) else $error("spurious command fault");
  property p_gclr;
    wr_s && pwdata[0] && v_q && a_q[15:10] == `PIO_GLOBAL_CLEAR_ADDR |-> ##[0:2] global_clear;
  endproperty
  a_gclr: assert property (p_gclr) else $error("global clear missing");
  property p_sel;
    v_q |-> subchannel_select_onehot == (a_q[9] ? 8'h00 : 8'h01 << a_q[8:6]);
  endproperty
  a_sel: assert property (p_sel) else $error("subchannel decode");
  property p_drv;
    (|addr_pos || |addr_neg) |-> address_drive_strobe && |subchannel_select_onehot
      && (addr_pos & addr_neg) == 6'h00;
  endproperty
  a_drv: assert property (p_drv) else $error("address drive ungated");
  property p_strb;
    $fell(command_lead_strobe) |-> n_q == `PIO_BUS_PULSE_CYC;
  endproperty
  a_strb: assert property (p_strb) else $error("command strobe width");
  property p_rclr;
    $fell(receiver_reset_enable) |-> ##[0:3] receiver_clear_pulse;
  endproperty
  a_rclr: assert property (p_rclr) else $error("receiver clear missing");
  c_gclr: cover property (global_clear);
  c_flt: cover property (multi_command_fault);
  c_strb: cover property ($fell(command_lead_strobe));
  c_rclr: cover property (receiver_clear_pulse);
endmodule
bind pio_channel pio_channel_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .receiver_reset_enable, .command_lead_strobe, .command_set_inhibit, .present_cmd,
  .subchannel_select_onehot, .address_drive_strobe, .addr_pos, .addr_neg, .info_gate_block,
  .multi_command_fault, .receiver_clear_pulse, .global_clear);
`default_nettype wire

// file: verif/pio_periph.sv
`timescale 1ns/1ps
`default_nettype none
module pio_periph (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [6:0] cmd_pos,
  input wire logic [6:0] cmd_neg,
  input wire logic bad,
  input wire logic [7:0] slow,
  output logic handshake_in_pos,
  output logic handshake_in_neg,
  output logic device_idle_response,
  output logic fault_response_lead,
  output logic interrupt_in,
  output logic [4:0] check_leads,
  output logic [17:0] info_rx_pulse
);
  localparam logic [7:0] LO = 8'h5a;
  localparam logic [7:0] HI = 8'hc3;
  logic sync_q;
  logic pend_q;
  logic [7:0] dly_q;
  assign handshake_in_pos = sync_q;
  assign handshake_in_neg = ~sync_q;
  assign device_idle_response = ~pend_q;
  assign fault_response_lead = bad & sync_q;
  assign interrupt_in = 1'b0;
  // two subchannels answering turn the two-of-five code into three ones
  assign check_leads = bad ? 5'h07 : 5'h03;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 1'b0;
      pend_q <= 1'b0;
      dly_q <= '0;
      info_rx_pulse <= '0;
    end else begin
      info_rx_pulse <= '0;
      if (|cmd_pos) begin
        pend_q <= 1'b1;
        dly_q <= slow;
      end else if (pend_q && dly_q == 8'h00) begin
        pend_q <= 1'b0;
        sync_q <= 1'b1;
        info_rx_pulse <= {~^HI, HI, ~^LO, LO};
      end else if (pend_q) begin
        dly_q <= dly_q - 8'h01;
      end
      if (&cmd_neg) sync_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verif/parallel_io_channel_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pio_params.svh"
module parallel_io_channel_sequencer_test;
  import pio_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bad = 0;
  logic [7:0] paddr = '0, dly = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, receiver_reset_enable, command_lead_strobe, command_set_inhibit;
  logic main_channel_selected, address_drive_strobe, info_gate_block, multi_command_fault;
  logic receiver_clear_pulse, global_clear, power_on_preset, gc_seen = 0, pp_seen = 0;
  logic handshake_in_pos, handshake_in_neg, device_idle_response, fault_response_lead;
  logic interrupt_in;
  pio_cmd_onehot_t present_cmd;
  logic [7:0] subchannel_select_onehot;
  logic [5:0] addr_pos, addr_neg;
  logic [6:0] cmd_pos, cmd_neg;
  logic [4:0] check_leads;
  logic [17:0] info_rx_pulse;
  logic [63:0] note;
  logic [63:0] exp_q[$];
  logic [2:0] sb;
  int bad_count = 0, total_checks = 0, seed, k, n;
  always #4 pclk = ~pclk;
  pio_channel dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr(), .chan_clk_out(), .receiver_reset_enable, .command_lead_strobe,
    .command_set_inhibit, .present_cmd, .main_channel_selected, .subchannel_select_onehot,
    .address_drive_strobe, .command_drive_strobe(), .addr_pos, .addr_neg, .cmd_pos, .cmd_neg,
    .info_pos(), .info_neg(), .info_gate_block, .multi_command_fault, .receiver_clear_pulse,
    .global_clear, .power_on_preset, .handshake_in_pos, .handshake_in_neg,
    .device_idle_response, .fault_response_lead, .interrupt_in, .check_leads, .info_rx_pulse);
  pio_periph periph (.pclk, .presetn, .cmd_pos, .cmd_neg, .bad, .slow(dly), .handshake_in_pos,
    .handshake_in_neg, .device_idle_response, .fault_response_lead, .interrupt_in,
    .check_leads, .info_rx_pulse);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e & m});
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = info_gate_block;
      1: pick = command_set_inhibit;
      2: pick = receiver_clear_pulse;
      default: pick = multi_command_fault;
    endcase
  endfunction
  // samples on the falling edge so register updates have landed
  task automatic wt(input int s, input logic v, input int lim);
    int i;
    i = 0;
    @(negedge pclk);
    while (pick(s) !== v && i < lim) begin
      @(negedge pclk);
      i++;
    end
    total_checks++;
    if (pick(s) !== v) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, pick(s), v);
      end_sim();
    end
    @(posedge pclk);
  endtask
  task automatic pul(input logic [31:0] s);
    wr(`PIO_STROBE_OFS, s);
    wt(1, 1'b0, 300);
    wt(1, 1'b1, 300);
  endtask
  task automatic first(input logic [15:0] a, input logic [2:0] c);
    wr(`PIO_ADDR_OFS, {16'h0, a});
    wr(`PIO_CMDSEL_OFS, {29'h0, c});
    wr(`PIO_DATA_OFS, $random(seed));
    wr(`PIO_STROBE_OFS, c == 3'd2 ? 32'h40 : 32'h100);
    wt(0, 1'b1, 300);
  endtask
  always @(posedge pclk) begin
    if (global_clear === 1'b1) gc_seen <= 1'b1;
    if (power_on_preset === 1'b1) pp_seen <= 1'b1;
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      chk(prdata & note[63:32], note[31:0]);
    end
  end
  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    end_sim();
  end
  initial begin
    seed = 44559;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, pp_seen}, 32'h1);
    rd(`PIO_STATUS_OFS, 32'h0, 32'h3ffe);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0, 32'hffffffff);
    $display("test reset done");
    for (k = 0; k < 6; k++) begin
      sb = 3'($random(seed));
      // reply must land before the readback after the third strobe
      dly <= 8'($random(seed)) & 8'h7f;
      first({6'h01, 1'b0, sb, 6'h15}, 3'(k));
      chk({25'h0, present_cmd}, 32'h1 << k);
      chk({23'h0, main_channel_selected, subchannel_select_onehot}, 32'h100 | (1 << sb));
      pul(32'h8);
      rd(`PIO_STATUS_OFS, 32'h2a, 32'h3a);
      pul(32'h4);
      rd(`PIO_STATUS_OFS, 32'h2a, 32'h3a);
      rd(`PIO_READBACK_OFS, 32'h3875a, 32'h3ffff);
      wr(`PIO_STROBE_OFS, 32'h2);
      wt(2, 1'b1, 20);
      wt(0, 1'b0, 300);
      rd(`PIO_STATUS_OFS, 32'h0, 32'h3a);
    end
    $display("test sequences done");
    wr(`PIO_STROBE_OFS, 32'h8);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      if (command_set_inhibit !== 1'b1) n++;
    end
    chk(n, 0);
    wr(`PIO_STROBE_OFS, 32'h2);
    // let the closing address pulse finish before the next first strobe
    repeat (4 * `PIO_HALF_CYC + 4) @(posedge pclk);
    first(16'h0440, 3'd0);
    pul(32'h200);
    rd(`PIO_STATUS_OFS, 32'h20, 32'h20);
    pul(32'h400);
    rd(`PIO_STATUS_OFS, 32'h0, 32'h20);
    wr(`PIO_STROBE_OFS, 32'h800);
    rd(`PIO_STATUS_OFS, 32'h40, 32'h40);
    wt(1, 1'b0, 300);
    wt(1, 1'b1, 300);
    rd(`PIO_STATUS_OFS, 32'h20, 32'h60);
    wr(`PIO_DATA_OFS, 32'h3);
    wr(`PIO_STROBE_OFS, 32'h1);
    wr(`PIO_STROBE_OFS, 32'h8);
    wt(3, 1'b1, 300);
    wt(1, 1'b1, 300);
    wr(`PIO_STROBE_OFS, 32'h2);
    wt(0, 1'b0, 300);
    $display("test dma and fault done");
    bad <= 1'b1;
    first(16'h0480, 3'd1);
    repeat (2 * `PIO_HALF_CYC + 10) @(posedge pclk);
    rd(`PIO_STATUS_OFS, 32'h3000, 32'h3000);
    bad <= 1'b0;
    wr(`PIO_STROBE_OFS, 32'h2);
    wt(0, 1'b0, 300);
    $display("test check code done");
    wr(`PIO_ADDR_OFS, 32'h0400);
    wr(`PIO_DATA_OFS, 32'h40);
    wr(`PIO_STROBE_OFS, 32'h1);
    rd(`PIO_STATUS_OFS, 32'h200, 32'h200);
    rd(`PIO_READBACK_OFS, 32'h400000, 32'h7f0000);
    wr(`PIO_STROBE_OFS, 32'h80);
    rd(`PIO_STATUS_OFS, 32'h400, 32'h600);
    $display("test maintenance done");
    first(16'h0440, 3'd0);
    wr(`PIO_ADDR_OFS, 32'h7c00);
    wr(`PIO_STROBE_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, gc_seen}, 32'h1);
    rd(`PIO_STATUS_OFS, 32'h0, 32'h1fe);
    $display("test global clear done");
    end_sim();
  end
endmodule
`default_nettype wire
